// >>> afesc_pkg.sv
// shared constants for the front-end serial control link
package afesc_pkg;
  // serial word layout, test flag shifted first
  localparam int WORD_BITS   = 16;
  localparam int TEST_BIT    = 15;
  localparam int ADDR_MSB    = 14;
  localparam int ADDR_LSB    = 12;
  localparam int DATA_MSB    = 11;
  // register addresses on the serial word
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_GAIN   = 3'h1;
  localparam logic [2:0] ADDR_PED    = 3'h2;
  localparam logic [2:0] ADDR_POL    = 3'h3;
  localparam logic [2:0] ADDR_DAC_A  = 3'h4;
  localparam logic [2:0] ADDR_DAC_B  = 3'h5;
  // defaults
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam logic [9:0] GAIN_RST    = 10'h080;
  localparam logic [3:0] PED_RST     = 4'h8;
  localparam logic [2:0] POL_RST     = 3'h0;
  localparam logic [7:0] DAC_RST     = 8'h00;
  // field positions
  localparam int MODE_CHIP_SB  = 0;
  localparam int MODE_DACA_SB  = 1;
  localparam int MODE_DACB_SB  = 2;
  localparam int POL_DUMMY     = 0;
  localparam int POL_BLACK     = 1;
  localparam int POL_SAMPLE    = 2;
  // conversion-clock edges from latch to register update
  localparam logic [2:0] UPDATE_EDGES = 3'h5;
  // clock half periods in ns, rounded up to hclk cycles
  localparam int HCLK_NS        = 10;
  localparam int SCLK_HALF_NS   = 60;
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + HCLK_NS - 1) / HCLK_NS;
  localparam int CONV_HALF_NS   = 40;
  localparam int CONV_HALF_CYC  = (CONV_HALF_NS + HCLK_NS - 1) / HCLK_NS;
  // controller register offsets and fields
  localparam logic [3:0] OFF_WORD   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_PINS   = 4'h8;
  localparam int PIN_RESET   = 0;
  localparam int PIN_BLACK   = 1;
  localparam int PIN_DUMMY   = 2;
  localparam int PIN_REFS    = 3;
  localparam int PIN_DATAS   = 4;
  localparam int PIN_PREBLANK_INPUT_N  = 5;
  localparam int PIN_BITS    = 6;
  localparam logic [5:0] PINS_RST = 6'h3e;
endpackage

// >>> afesc_if.sv
// link between the camera controller and the front end
`timescale 1ns/1ns
`default_nettype none
interface afesc_if;
  logic       serial_load_strobe;
  logic       serial_clock;
  logic       serial_data_in;
  logic       afe_reset_n;
  logic       conversion_clock;
  logic       reference_sample_pulse;
  logic       data_sample_pulse;
  logic       black_clamp_pulse;
  logic       dummy_clamp_pulse;
  logic       preblank_input;
  logic [9:0] afe_data;
  modport ctrl (
    output serial_load_strobe, serial_clock, serial_data_in, afe_reset_n,
    output conversion_clock, reference_sample_pulse, data_sample_pulse,
    output black_clamp_pulse, dummy_clamp_pulse, preblank_input,
    input  afe_data
  );
  modport dev (
    input  serial_load_strobe, serial_clock, serial_data_in, afe_reset_n,
    input  conversion_clock, reference_sample_pulse, data_sample_pulse,
    input  black_clamp_pulse, dummy_clamp_pulse, preblank_input,
    output afe_data
  );
endinterface
`default_nettype wire

// >>> afesc_dev.sv
// front-end end: serial port, feature registers, pulse masking
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module afesc_dev (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  afesc_if.dev            link,
  input  wire logic [9:0] adc_code,
  output logic      [2:0] operating_mode,
  output logic      [9:0] amplifier_gain,
  output logic      [3:0] black_pedestal_level,
  output logic      [5:0] pedestal_lsb,
  output logic      [2:0] pulse_polarity,
  output logic      [7:0] aux_dac_a_code,
  output logic      [7:0] aux_dac_b_code,
  output logic            chip_standby,
  output logic            dac_a_standby,
  output logic            dac_b_standby,
  output logic            conv_clock_gated,
  output logic            ref_sample_gated,
  output logic            data_sample_gated,
  output logic            black_clamp_gated,
  output logic            dummy_clamp_gated,
  output logic            ref_sample_active,
  output logic            data_sample_active,
  output logic            black_loop_close,
  output logic            input_clamp_close
);
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] pin_in;
  logic             load_s;
  logic             sclk_s;
  logic             serial_data_in_s;
  logic             rst_n_s;
  logic             conv_s;
  logic             load_prev_reg;
  logic             sclk_prev_reg;
  logic             conv_prev_reg;
  logic             sclk_rise;
  logic             load_rise;
  logic             load_fall;
  logic             conv_rise;
  logic [15:0]      shift_reg;
  logic [4:0]       bit_cnt_reg;
  logic [15:0]      latch_reg;
  logic             pending_reg;
  logic [2:0]       edge_cnt_reg;
  logic             apply;
  logic [2:0]       waddr;
  logic [9:0]       data_out_reg;
  logic             masked_ref;
  logic             masked_dat;
  logic             masked_blk;
  logic             masked_dum;

  assign pin_in = {link.preblank_input, link.dummy_clamp_pulse,
                   link.black_clamp_pulse, link.data_sample_pulse,
                   link.reference_sample_pulse, link.conversion_clock,
                   link.afe_reset_n, link.serial_data_in,
                   link.serial_clock, link.serial_load_strobe};

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 10'h01f;
      sync2_reg <= 10'h01f;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign load_s  = sync2_reg[0];
  assign sclk_s  = sync2_reg[1];
  assign serial_data_in_s = sync2_reg[2];
  assign rst_n_s = sync2_reg[3];
  assign conv_s  = sync2_reg[4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b1;
      conv_prev_reg <= 1'b1;
    end else begin
      load_prev_reg <= load_s;
      sclk_prev_reg <= sclk_s;
      conv_prev_reg <= conv_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign load_rise = load_s & ~load_prev_reg;
  assign load_fall = ~load_s & load_prev_reg;
  assign conv_rise = conv_s & ~conv_prev_reg;

  // shift msb first so the test flag lands on top
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (load_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (!load_s && sclk_rise) begin
      shift_reg <= {shift_reg[14:0], serial_data_in_s};
      if (bit_cnt_reg != 5'h1f) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // short or long frames are dropped, never half applied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_reg    <= 16'h0000;
      pending_reg  <= 1'b0;
      edge_cnt_reg <= 3'h0;
    end else if (load_rise && bit_cnt_reg == 5'h10) begin
      latch_reg    <= shift_reg;
      pending_reg  <= 1'b1;
      edge_cnt_reg <= 3'h0;
    end else if (pending_reg && conv_rise) begin
      edge_cnt_reg <= edge_cnt_reg + 3'h1;
      if (edge_cnt_reg == afesc_pkg::UPDATE_EDGES - 3'h1) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // sync delay under one conversion period keeps this at 5 or 6
  assign apply = pending_reg && conv_rise &&
                 edge_cnt_reg == afesc_pkg::UPDATE_EDGES - 3'h1;
  assign waddr = latch_reg[afesc_pkg::ADDR_MSB:afesc_pkg::ADDR_LSB];

  // writes go through regardless of standby
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      operating_mode       <= afesc_pkg::MODE_RST;
      amplifier_gain       <= afesc_pkg::GAIN_RST;
      black_pedestal_level <= afesc_pkg::PED_RST;
      pulse_polarity       <= afesc_pkg::POL_RST;
      aux_dac_a_code       <= afesc_pkg::DAC_RST;
      aux_dac_b_code       <= afesc_pkg::DAC_RST;
    end else if (!rst_n_s) begin
      operating_mode       <= afesc_pkg::MODE_RST;
      amplifier_gain       <= afesc_pkg::GAIN_RST;
      black_pedestal_level <= afesc_pkg::PED_RST;
      pulse_polarity       <= afesc_pkg::POL_RST;
      aux_dac_a_code       <= afesc_pkg::DAC_RST;
      aux_dac_b_code       <= afesc_pkg::DAC_RST;
    end else if (apply && !latch_reg[afesc_pkg::TEST_BIT]) begin
      unique case (waddr)
        afesc_pkg::ADDR_MODE:  operating_mode       <= latch_reg[2:0];
        afesc_pkg::ADDR_GAIN:  amplifier_gain       <= latch_reg[9:0];
        afesc_pkg::ADDR_PED:   black_pedestal_level <= latch_reg[3:0];
        afesc_pkg::ADDR_POL:   pulse_polarity       <= latch_reg[2:0];
        afesc_pkg::ADDR_DAC_A: aux_dac_a_code       <= latch_reg[7:0];
        afesc_pkg::ADDR_DAC_B: aux_dac_b_code       <= latch_reg[7:0];
        default: begin
        end
      endcase
    end
  end

  assign pedestal_lsb  = {black_pedestal_level, 2'b00};
  assign chip_standby  = operating_mode[afesc_pkg::MODE_CHIP_SB];
  assign dac_a_standby = operating_mode[afesc_pkg::MODE_DACA_SB];
  assign dac_b_standby = operating_mode[afesc_pkg::MODE_DACB_SB];

  // masked pins are held high in standby
  assign conv_clock_gated  = chip_standby | conv_s;
  assign masked_ref        = chip_standby | sync2_reg[5];
  assign masked_dat        = chip_standby | sync2_reg[6];
  assign masked_blk        = chip_standby | sync2_reg[7];
  assign masked_dum        = chip_standby | sync2_reg[8];
  assign ref_sample_gated  = masked_ref;
  assign data_sample_gated = masked_dat;
  assign black_clamp_gated = masked_blk;
  assign dummy_clamp_gated = masked_dum;

  // polarity bit equals the active level
  assign ref_sample_active  = !chip_standby &&
    (masked_ref == pulse_polarity[afesc_pkg::POL_SAMPLE]);
  assign data_sample_active = !chip_standby &&
    (masked_dat == pulse_polarity[afesc_pkg::POL_SAMPLE]);
  assign black_loop_close   = !chip_standby &&
    (masked_blk == pulse_polarity[afesc_pkg::POL_BLACK]);
  assign input_clamp_close  = ref_sample_active && !chip_standby &&
    (masked_dum == pulse_polarity[afesc_pkg::POL_DUMMY]);

  // output word moves on a conversion clock rise, and clears at once in standby
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_out_reg <= 10'h000;
    end else if (chip_standby) begin
      data_out_reg <= 10'h000;
    end else if (conv_rise) begin
      data_out_reg <= sync2_reg[9] ? adc_code : 10'h000;
    end
  end

  assign link.afe_data = data_out_reg;
endmodule
`default_nettype wire

// >>> afesc_ctrl.sv
// controller end: ahb-lite registers, serial writer, pulse pins
`timescale 1ns/1ns
`default_nettype none
module afesc_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  afesc_if.ctrl            link
);
  typedef enum logic [4:0] {
    AFESC_IDLE  = 5'b00001,
    AFESC_SETUP = 5'b00010,
    AFESC_LOW   = 5'b00100,
    AFESC_HIGH  = 5'b01000,
    AFESC_END   = 5'b10000
  } afesc_state_t;

  afesc_state_t state_reg;
  logic [15:0]  word_reg;
  logic [15:0]  tx_reg;
  logic [4:0]   bits_reg;
  logic [3:0]   tick_reg;
  logic         tick;
  logic [5:0]   pins_reg;
  logic [3:0]   conv_cnt_reg;
  logic         conv_reg;
  logic         wr_pend_reg;
  logic [3:0]   wr_off_reg;
  logic [31:0]  rdata_reg;
  logic         start;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // zero wait states; read data captured at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg  <= 4'h0;
      rdata_reg   <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_off_reg  <= haddr[3:0];
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr[3:0])
          afesc_pkg::OFF_WORD:   rdata_reg <= {16'h0000, word_reg};
          afesc_pkg::OFF_STATUS: rdata_reg <= {31'h0, state_reg != AFESC_IDLE};
          afesc_pkg::OFF_PINS:   rdata_reg <= {26'h0, pins_reg};
          default:               rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a word written while busy is dropped
  assign start = wr_pend_reg && wr_off_reg == afesc_pkg::OFF_WORD &&
                 state_reg == AFESC_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_reg <= 16'h0000;
      pins_reg <= afesc_pkg::PINS_RST;
    end else if (wr_pend_reg) begin
      if (start) begin
        word_reg <= hwdata[15:0];
      end
      if (wr_off_reg == afesc_pkg::OFF_PINS) begin
        pins_reg <= hwdata[5:0];
      end
    end
  end

  // shift clock divider runs only while a word is in flight
  assign tick = tick_reg == 4'(afesc_pkg::SCLK_HALF_CYC - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 4'h0;
    end else if (state_reg == AFESC_IDLE || tick) begin
      tick_reg <= 4'h0;
    end else begin
      tick_reg <= tick_reg + 4'h1;
    end
  end

  // strobe low whole frame, sixteen bits, then release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= AFESC_IDLE;
      tx_reg    <= 16'h0000;
      bits_reg  <= 5'h00;
    end else begin
      unique case (state_reg)
        AFESC_IDLE: begin
          if (start) begin
            tx_reg    <= hwdata[15:0];
            bits_reg  <= 5'h00;
            state_reg <= AFESC_SETUP;
          end
        end
        AFESC_SETUP: begin
          if (tick) begin
            state_reg <= AFESC_LOW;
          end
        end
        AFESC_LOW: begin
          if (tick) begin
            state_reg <= AFESC_HIGH;
          end
        end
        AFESC_HIGH: begin
          if (tick) begin
            tx_reg   <= {tx_reg[14:0], 1'b0};
            bits_reg <= bits_reg + 5'h01;
            state_reg <= (bits_reg == 5'h0f) ? AFESC_END : AFESC_LOW;
          end
        end
        AFESC_END: begin
          if (tick) begin
            state_reg <= AFESC_IDLE;
          end
        end
      endcase
    end
  end

  // data changes at the falling edge, stable at the rise
  assign link.serial_load_strobe = state_reg == AFESC_IDLE;
  assign link.serial_clock       = state_reg != AFESC_LOW;
  assign link.serial_data_in     = tx_reg[15];

  // free-running conversion clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt_reg <= 4'h0;
      conv_reg     <= 1'b0;
    end else if (conv_cnt_reg == 4'(afesc_pkg::CONV_HALF_CYC - 1)) begin
      conv_cnt_reg <= 4'h0;
      conv_reg     <= ~conv_reg;
    end else begin
      conv_cnt_reg <= conv_cnt_reg + 4'h1;
    end
  end

  assign link.conversion_clock       = conv_reg;
  assign link.afe_reset_n            = ~pins_reg[afesc_pkg::PIN_RESET];
  assign link.reference_sample_pulse = pins_reg[afesc_pkg::PIN_REFS];
  assign link.data_sample_pulse      = pins_reg[afesc_pkg::PIN_DATAS];
  assign link.dummy_clamp_pulse      = pins_reg[afesc_pkg::PIN_DUMMY];
  assign link.preblank_input         = pins_reg[afesc_pkg::PIN_PREBLANK_INPUT_N];
  // active-low clamp held inactive while preblank is low
  assign link.black_clamp_pulse      = pins_reg[afesc_pkg::PIN_BLACK] |
                                       ~pins_reg[afesc_pkg::PIN_PREBLANK_INPUT_N];
endmodule
`default_nettype wire

// >>> afesc_link_chk.sv
// checker: serial framing, conversion clock and output data on the link
`timescale 1ns/1ns
`default_nettype none
module afesc_link_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       serial_load_strobe,
  input wire logic       serial_clock,
  input wire logic       serial_data_in,
  input wire logic       afe_reset_n,
  input wire logic       conversion_clock,
  input wire logic       preblank_input,
  input wire logic [9:0] afe_data
);
  logic       sclk_prev_reg;
  logic [4:0] bits_reg;
  logic [4:0] preblank_input_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= serial_clock;
    end
  end
  // shift edges seen in the current frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_reg <= 5'h0;
    end else if (serial_load_strobe) begin
      bits_reg <= 5'h0;
    end else if (serial_clock && !sclk_prev_reg) begin
      bits_reg <= bits_reg + 5'h1;
    end
  end
  // saturates so a long blank cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preblank_input_reg <= 5'h0;
    end else if (preblank_input) begin
      preblank_input_reg <= 5'h0;
    end else if (preblank_input_reg != 5'h1f) begin
      preblank_input_reg <= preblank_input_reg + 5'h1;
    end
  end
  property p_sclk_idle;
    serial_load_strobe |-> serial_clock;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("shift clock low outside a frame");
  property p_setup;
    $fell(serial_load_strobe) |-> serial_clock [*3];
  endproperty
  a_setup: assert property (p_setup)
    else $error("shift clock moved too soon after strobe fall");
  property p_frame_len;
    $fell(serial_load_strobe) |-> ##[190:230] $rose(serial_load_strobe);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");
  property p_data_stable;
    $rose(serial_clock) |-> $stable(serial_data_in) ##1
      $stable(serial_data_in);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("serial data moved at shift clock rise");
  property p_bit_count;
    $rose(serial_load_strobe) |-> bits_reg == 5'h10;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("frame did not carry sixteen bits");
  property p_conv_clock;
    $rose(conversion_clock) |-> conversion_clock [*4] ##1
      !conversion_clock [*4] ##1 conversion_clock;
  endproperty
  a_conv_clock: assert property (p_conv_clock)
    else $error("conversion clock period or duty wrong");
  property p_data_on_conv;
    $changed(afe_data) && preblank_input && $past(preblank_input, 4)
      && afe_reset_n && $past(afe_reset_n, 4)
      |-> $past(conversion_clock) || $past(conversion_clock, 2);
  endproperty
  a_data_on_conv: assert property (p_data_on_conv)
    else $error("output data changed away from conversion clock");
  property p_preblank_zero;
    preblank_input_reg >= 5'h14 |-> afe_data == 10'h000;
  endproperty
  a_preblank_zero: assert property (p_preblank_zero)
    else $error("output data not zero during preblank");
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench: register writes travel the serial link to the front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [15:0] word;
    logic [2:0]  idx;
    logic [11:0] val;
  } afesc_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, operating_mode, pulse_polarity;
  logic [9:0]  adc_code, amplifier_gain;
  logic [3:0]  black_pedestal_level;
  logic [5:0]  pedestal_lsb;
  logic [7:0]  aux_dac_a_code, aux_dac_b_code;
  logic        chip_standby, dac_a_standby, dac_b_standby;
  logic        conv_clock_gated, ref_sample_gated, data_sample_gated;
  logic        black_clamp_gated, dummy_clamp_gated;
  logic        ref_sample_active, data_sample_active;
  logic        black_loop_close, input_clamp_close;
  logic [11:0] model [0:5];
  logic [15:0] mon_word, wire_word;
  logic [4:0]  mon_bits = 5'h0;
  logic [4:0]  wire_bits;
  logic        mon_sclk = 1'b1;
  int          fail_count = 0;
  int          samples_checked = 0;
  afesc_row_t  rows [0:9];
  afesc_if link_if ();
  afesc_ctrl afesc_ctrl_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link(link_if));
  afesc_dev afesc_dev_inst (.hclk(hclk), .hresetn(hresetn),
    .link(link_if), .adc_code(adc_code),
    .operating_mode(operating_mode), .amplifier_gain(amplifier_gain),
    .black_pedestal_level(black_pedestal_level),
    .pedestal_lsb(pedestal_lsb), .pulse_polarity(pulse_polarity),
    .aux_dac_a_code(aux_dac_a_code), .aux_dac_b_code(aux_dac_b_code),
    .chip_standby(chip_standby), .dac_a_standby(dac_a_standby),
    .dac_b_standby(dac_b_standby), .conv_clock_gated(conv_clock_gated),
    .ref_sample_gated(ref_sample_gated),
    .data_sample_gated(data_sample_gated),
    .black_clamp_gated(black_clamp_gated),
    .dummy_clamp_gated(dummy_clamp_gated),
    .ref_sample_active(ref_sample_active),
    .data_sample_active(data_sample_active),
    .black_loop_close(black_loop_close),
    .input_clamp_close(input_clamp_close));
  afesc_link_chk afesc_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .serial_load_strobe(link_if.serial_load_strobe),
    .serial_clock(link_if.serial_clock),
    .serial_data_in(link_if.serial_data_in),
    .afe_reset_n(link_if.afe_reset_n),
    .conversion_clock(link_if.conversion_clock),
    .preblank_input(link_if.preblank_input), .afe_data(link_if.afe_data));
  // independent wire monitor, msb arrives first
  always @(posedge hclk) begin
    mon_sclk <= link_if.serial_clock;
    if (link_if.serial_load_strobe) begin
      if (mon_bits != 5'h0) begin
        wire_word <= mon_word;
        wire_bits <= mon_bits;
      end
      mon_bits <= 5'h0;
    end else if (link_if.serial_clock && !mon_sclk) begin
      mon_word <= {mon_word[14:0], link_if.serial_data_in};
      mon_bits <= mon_bits + 5'h1;
    end
  end
  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one single word transfer; no wait count assumed
  task automatic ahb_xfer(input logic wr, input logic [3:0] off,
                          input logic [31:0] wdat);
    hsel <= 1'b1;
    haddr <= {28'h000_0000, off};
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdat;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic wait_frame;
    int n;
    n = 0;
    while (link_if.serial_load_strobe !== 1'b0 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (link_if.serial_load_strobe !== 1'b0) fail_count++;
    while (link_if.serial_load_strobe !== 1'b1 && n < 400) begin
      n++;
      @(posedge hclk);
    end
    if (link_if.serial_load_strobe !== 1'b1) fail_count++;
  endtask
  task automatic wait_conv(input int k);
    int n;
    logic p;
    n = 0;
    p = link_if.conversion_clock;
    while (k > 0 && n < 200) begin
      @(posedge hclk);
      if (link_if.conversion_clock && !p) k--;
      p = link_if.conversion_clock;
      n++;
    end
    if (k > 0) fail_count++;
  endtask
  task automatic send_word(input logic [15:0] w);
    ahb_xfer(1'b1, afesc_pkg::OFF_WORD, {16'h0000, w});
    wait_frame;
    repeat (80) @(posedge hclk);
  endtask
  task automatic set_pins(input logic [7:0] v);
    ahb_xfer(1'b1, afesc_pkg::OFF_PINS, {24'h00_0000, v});
    repeat (30) @(posedge hclk);
  endtask
  task automatic check_regs;
    check_val("mode", 16'(model[0]), 16'(operating_mode));
    check_val("gain", 16'(model[1]), 16'(amplifier_gain));
    check_val("pedestal", 16'(model[2]), 16'(black_pedestal_level));
    check_val("ped_lsb", 16'({model[2], 2'b00}), 16'(pedestal_lsb));
    check_val("polarity", 16'(model[3]), 16'(pulse_polarity));
    check_val("dac_a", 16'(model[4]), 16'(aux_dac_a_code));
    check_val("dac_b", 16'(model[5]), 16'(aux_dac_b_code));
    check_val("standby", 16'(model[0]), 16'({dac_b_standby,
      dac_a_standby, chip_standby}));
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #300_000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    adc_code = 10'h2aa;
    model = '{12'h000, 12'h080, 12'h008, 12'h000, 12'h000, 12'h000};
    // reserved and test words carry idx 7: nothing may change
    rows = '{'{16'h0005, 3'h0, 12'h005}, '{16'h1155, 3'h1, 12'h155},
      '{16'h200f, 3'h2, 12'h00f}, '{16'h3007, 3'h3, 12'h007},
      '{16'h40a5, 3'h4, 12'h0a5}, '{16'h50ff, 3'h5, 12'h0ff},
      '{16'h6abc, 3'h7, 12'h000}, '{16'h8123, 3'h7, 12'h000},
      '{16'h0000, 3'h0, 12'h000}, '{16'h3000, 3'h3, 12'h000}};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs;
    $display("test defaults done");
    // rows 1 to 8 run in standby: port must keep working
    for (int i = 0; i < 10; i++) begin
      send_word(rows[i].word);
      if (rows[i].idx != 3'h7) model[rows[i].idx] = rows[i].val;
      check_regs;
      check_val("wire_word", rows[i].word, wire_word);
      check_val("wire_bits", 16'h0010, 16'(wire_bits));
      ahb_xfer(1'b0, afesc_pkg::OFF_WORD, 32'h0000_0000);
      check_val("word_reg", rows[i].word, rdata[15:0]);
    end
    $display("test table done");
    ahb_xfer(1'b1, afesc_pkg::OFF_WORD, 32'h0000_1200);
    wait_frame;
    wait_conv(4);
    check_val("gain_early", 16'h0155, 16'(amplifier_gain));
    wait_conv(2);
    check_val("gain_late", 16'h0200, 16'(amplifier_gain));
    model[1] = 12'h200;
    $display("test latency done");
    // second word lands while busy and is dropped
    ahb_xfer(1'b1, afesc_pkg::OFF_WORD, 32'h0000_4011);
    ahb_xfer(1'b1, afesc_pkg::OFF_WORD, 32'h0000_4022);
    ahb_xfer(1'b0, afesc_pkg::OFF_STATUS, 32'h0000_0000);
    check_val("busy", 16'h0001, rdata[15:0]);
    wait_frame;
    repeat (80) @(posedge hclk);
    model[4] = 12'h011;
    check_regs;
    ahb_xfer(1'b0, 4'hc, 32'h0000_0000);
    check_val("unmapped", 16'h0000, rdata[15:0]);
    $display("test busy done");
    set_pins(8'h20);
    ahb_xfer(1'b0, afesc_pkg::OFF_PINS, 32'h0000_0000);
    check_val("pins", 16'h0020, rdata[15:0]);
    check_val("ref_act", 16'h0001, 16'(ref_sample_active));
    check_val("data_act", 16'h0001, 16'(data_sample_active));
    check_val("black_loop", 16'h0001, 16'(black_loop_close));
    check_val("in_clamp", 16'h0001, 16'(input_clamp_close));
    check_val("afe_data", 16'h02aa, 16'(link_if.afe_data));
    send_word(16'h3004);
    check_val("ref_hi", 16'h0000, 16'(ref_sample_active));
    send_word(16'h0001);
    check_val("gated", 16'h001f, 16'({conv_clock_gated, ref_sample_gated,
      data_sample_gated, black_clamp_gated, dummy_clamp_gated}));
    check_val("sb_loop", 16'h0000, 16'(black_loop_close));
    check_val("sb_data", 16'h0000, 16'(link_if.afe_data));
    send_word(16'h0000);
    set_pins(8'h00);
    check_val("preblank_input_data", 16'h0000, 16'(link_if.afe_data));
    check_val("preblank_input_black", 16'h0000, 16'(black_loop_close));
    $display("test pulses done");
    set_pins(8'h3f);
    model = '{12'h000, 12'h080, 12'h008, 12'h000, 12'h000, 12'h000};
    check_regs;
    set_pins(8'h3e);
    send_word(16'h50aa);
    check_val("dac_b_pre", 16'h00aa, 16'(aux_dac_b_code));
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check_regs;
    $display("test resets done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
